// ---- hw/asr_ctrl.v ----
`timescale 1ns/1ps
`include "asr_ctrl_regs.vh"

// Function
// - a write happens whenever select and write strobe are both low, whatever output enable does.
// - with select and output enable low and the strobe high the memory drives the addressed byte.
// - a write ends at whichever of select or strobe rises first.
// - write data is held valid around the rising edge that ends the write.
// - the host waits at least 100 us after power before the first access.
// - a strobe-ended write with output enable low lasts at least float time plus data setup.
// - the host never drives data while the memory may still be driving the lines.
// - a read has its address valid by the fall of select and the strobe high throughout.
module asr_ctrl #(
    parameter ADDR_W    = `ASR_ADDR_W,
    parameter DATA_W    = `ASR_DATA_W,
    parameter POWER_CYC = `ASR_POWER_UP_CYC
) (
    // clock and reset
    input  wire              clock,
    input  wire              rst,
    // user request
    input  wire              reqValid,
    input  wire              reqWrite,
    input  wire [ADDR_W-1:0] reqAddr,
    input  wire [DATA_W-1:0] reqData,
    output reg               reqReady,
    // user answer
    output reg               rspValid,
    output reg  [DATA_W-1:0] rspData,
    // memory pins
    output reg  [ADDR_W-1:0] addressLines,
    output reg               chipSelectN,
    output reg               outEnableN,
    output reg               writeStrobeN,
    input  wire [DATA_W-1:0] dataLinesIn,
    output reg  [DATA_W-1:0] dataLinesOut,
    output reg               dataLinesOeN
);
    // binary state codes
    localparam ST_POWER = 3'h0;
    localparam ST_IDLE  = 3'h1;
    localparam ST_RSET  = 3'h2;
    localparam ST_READ  = 3'h3;
    localparam ST_WSET  = 3'h4;
    localparam ST_WRITE = 3'h5;
    localparam ST_WEND  = 3'h6;

    localparam TW = 16;
    localparam integer  READ_I    = `ASR_READ_CYC;
    localparam [TW-1:0] READ_CYC  = READ_I[TW-1:0];
    // strobe-ended write pulse covers float plus setup and the pulse minimum
    localparam integer WR_A = `ASR_FLOAT_CYC + `ASR_SETUP_CYC;
    localparam integer WR_B = `ASR_WRITE_CYC;
    localparam integer  WR_MAX    = (WR_A > WR_B) ? WR_A : WR_B;
    localparam [TW-1:0] WRITE_CYC = WR_MAX[TW-1:0];
    // timer is 16 bits: a longer power wait needs a wider TW
    localparam integer  POWER_I   = POWER_CYC;
    localparam [TW-1:0] POWER_LD  = POWER_I[TW-1:0];

    reg [2:0]    state_r;
    reg [2:0]    state_nxt;
    reg          timerLoad;
    reg [TW-1:0] timerValue;
    wire         timerDone;
    reg          started_r;

    // one shared timer: power wait, read window and strobe length
    asr_wait_timer #(.W(TW)) timer (
        .clock (clock),
        .rst   (rst),
        .load  (timerLoad),
        .value (timerValue),
        .done  (timerDone)
    );

    // power-up wait load fires once after reset release
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            started_r <= 1'b0;
        end else begin
            started_r <= 1'b1;
        end
    end

    // next state and timer loads
    always @* begin
        state_nxt  = state_r;
        timerLoad  = 1'b0;
        timerValue = {TW{1'b0}};
        case (state_r)
            ST_POWER: begin
                if (!started_r) begin
                    timerLoad  = 1'b1;
                    timerValue = POWER_LD;
                end else if (timerDone) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (reqValid) begin
                    state_nxt = reqWrite ? ST_WSET : ST_RSET;
                end
            end
            ST_RSET: begin
                state_nxt  = ST_READ;
                timerLoad  = 1'b1;
                timerValue = READ_CYC;
            end
            ST_READ: begin
                if (timerDone) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_WSET: begin
                state_nxt  = ST_WRITE;
                timerLoad  = 1'b1;
                timerValue = WRITE_CYC;
            end
            ST_WRITE: begin
                if (timerDone) begin
                    state_nxt = ST_WEND;
                end
            end
            ST_WEND: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // every pin registered so no decode glitch reaches the memory
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r      <= ST_POWER;
            reqReady     <= 1'b0;
            rspValid     <= 1'b0;
            rspData      <= {DATA_W{1'b0}};
            addressLines <= {ADDR_W{1'b0}};
            chipSelectN  <= 1'b1;
            outEnableN   <= 1'b1;
            writeStrobeN <= 1'b1;
            dataLinesOut <= {DATA_W{1'b0}};
            dataLinesOeN <= 1'b1;
        end else begin
            state_r  <= state_nxt;
            rspValid <= 1'b0;
            // ready looks one cycle ahead at the next state;
            // a request taken in idle drops it at once
            reqReady <= (state_nxt == ST_IDLE) && (state_r != ST_IDLE || !reqValid);
            case (state_r)
                ST_POWER: begin
                    // pins parked until the supply has settled
                    chipSelectN  <= 1'b1;
                    outEnableN   <= 1'b1;
                    writeStrobeN <= 1'b1;
                    dataLinesOeN <= 1'b1;
                end
                ST_IDLE: begin
                    if (reqValid) begin
                        reqReady     <= 1'b0;
                        // address settles before select falls
                        addressLines <= reqAddr;
                        dataLinesOut <= reqData;
                    end else begin
                        // deselected between accesses: standby power
                        chipSelectN  <= 1'b1;
                        outEnableN   <= 1'b1;
                        writeStrobeN <= 1'b1;
                        dataLinesOeN <= 1'b1;
                    end
                end
                ST_RSET: begin
                    // strobe held high so the window is a pure read
                    chipSelectN  <= 1'b0;
                    outEnableN   <= 1'b0;
                    writeStrobeN <= 1'b1;
                end
                ST_READ: begin
                    if (timerDone) begin
                        rspValid    <= 1'b1;
                        rspData     <= dataLinesIn;
                        chipSelectN <= 1'b1;
                        outEnableN  <= 1'b1;
                    end
                end
                ST_WSET: begin
                    // enable kept high so the memory never drives against us
                    outEnableN   <= 1'b1;
                    chipSelectN  <= 1'b0;
                    writeStrobeN <= 1'b0;
                    dataLinesOeN <= 1'b0;
                end
                ST_WRITE: begin
                    if (timerDone) begin
                        // strobe ends the write; select lifts a cycle later
                        writeStrobeN <= 1'b1;
                    end
                end
                ST_WEND: begin
                    chipSelectN  <= 1'b1;
                    // data held a cycle past the strobe edge: zero hold met
                    dataLinesOeN <= 1'b1;
                end
                default: begin
                    chipSelectN  <= 1'b1;
                    outEnableN   <= 1'b1;
                    writeStrobeN <= 1'b1;
                    dataLinesOeN <= 1'b1;
                end
            endcase
        end
    end
endmodule // asr_ctrl

// ---- hw/asr_ctrl_regs.vh ----
`ifndef ASR_CTRL_REGS_VH
`define ASR_CTRL_REGS_VH

// memory geometry
`define ASR_ADDR_W            19
`define ASR_DATA_W            8

// clock period in ns (100 MHz)
`define ASR_CLK_NS            10

// device timing figures, in their own units
`define ASR_POWER_UP_WAIT_US  100
`define ASR_READ_CYCLE_NS     10
`define ASR_WRITE_PULSE_NS    7
`define ASR_STROBE_TO_FLOAT_NS 5
`define ASR_WRITE_DATA_SETUP_NS 6

// derived cycle counts: least times round up
`define ASR_POWER_UP_CYC  ((`ASR_POWER_UP_WAIT_US * 1000 + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_READ_CYC      ((`ASR_READ_CYCLE_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_FLOAT_CYC     ((`ASR_STROBE_TO_FLOAT_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_SETUP_CYC     ((`ASR_WRITE_DATA_SETUP_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_WRITE_CYC     ((`ASR_WRITE_PULSE_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)

`endif

// ---- hw/asr_wait_timer.v ----
`timescale 1ns/1ps
// loadable down counter, done while zero
module asr_wait_timer #(
    parameter W = 16
) (
    // clock and reset
    input  wire         clock,
    input  wire         rst,
    // control
    input  wire         load,
    input  wire [W-1:0] value,
    // status
    output wire         done
);
    reg [W-1:0] count_r;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            count_r <= {W{1'b0}};
        end else if (load) begin
            count_r <= value;
        end else if (count_r != {W{1'b0}}) begin
            count_r <= count_r - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign done = (count_r == {W{1'b0}});
endmodule // asr_wait_timer

// ---- test/asr_ctrl_asserts.sv ----
`timescale 1ns/1ps
module asr_ctrl_asserts #(
    parameter ADDR_W = 19, parameter DATA_W = 8, parameter POWER_CYC = 10000
) (
    input logic              clock,
    input logic              rst,
    input logic              reqValid,
    input logic              reqWrite,
    input logic              reqReady,
    input logic              rspValid,
    input logic [ADDR_W-1:0] addressLines,
    input logic              chipSelectN,
    input logic              outEnableN,
    input logic              writeStrobeN,
    input logic [DATA_W-1:0] dataLinesOut,
    input logic              dataLinesOeN
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    int unsigned upCnt;
    always @(posedge clock or posedge rst)
        if (rst) upCnt <= 0;
        else if (upCnt < POWER_CYC) upCnt <= upCnt + 1;
    sequence strobeLow3; !writeStrobeN [*3] ##1 writeStrobeN; endsequence
    sequence csLate; !chipSelectN && !dataLinesOeN ##1 chipSelectN && dataLinesOeN; endsequence
    pwr_wait_a: assert property (upCnt < POWER_CYC |-> chipSelectN)
        else $error("access during power wait");
    wr_drive_a: assert property (!chipSelectN && !writeStrobeN |-> !dataLinesOeN)
        else $error("write without data driven");
    no_clash_a: assert property (!outEnableN |-> writeStrobeN && dataLinesOeN)
        else $error("host drives while memory outputs on");
    wr_pulse_a: assert property ($fell(writeStrobeN) |-> strobeLow3)
        else $error("strobe pulse length wrong");
    wr_end_a: assert property ($rose(writeStrobeN) |-> csLate)
        else $error("write end order wrong");
    wr_hold_a: assert property ($rose(writeStrobeN) |-> $stable(dataLinesOut))
        else $error("data moved at write end");
    addr_hold_a: assert property (!chipSelectN && !$past(chipSelectN)
        |-> $stable(addressLines))
        else $error("address moved while selected");
    rd_addr_a: assert property ($fell(chipSelectN) |-> $stable(addressLines))
        else $error("address late at select");
    rd_answer_a: assert property (reqValid && reqReady && !reqWrite |-> ##[2:5] rspValid)
        else $error("read answer missing");
    idle_pins_a: assert property (chipSelectN |-> writeStrobeN && outEnableN)
        else $error("strobe active while deselected");
endmodule // asr_ctrl_asserts
bind asr_ctrl asr_ctrl_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .POWER_CYC(POWER_CYC)) u_chk (
    .clock(clock), .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite), .reqReady(reqReady),
    .rspValid(rspValid), .addressLines(addressLines), .chipSelectN(chipSelectN),
    .outEnableN(outEnableN), .writeStrobeN(writeStrobeN), .dataLinesOut(dataLinesOut),
    .dataLinesOeN(dataLinesOeN));

// ---- test/asr_sram_model.sv ----
`timescale 1ns/1ps
// behavioural memory on the far side of the pins
module asr_sram_model (
    // memory pins
    input  wire [18:0] addressLines,
    input  wire        chipSelectN,
    input  wire        outEnableN,
    input  wire        writeStrobeN,
    // host drive and resolved wire
    input  wire [7:0]  hostData,
    input  wire        hostOeN,
    output wire [7:0]  dataLines
);
    logic [7:0] mem [0:524287];
    logic [7:0] floatV = 8'h5a;
    wire wrAct = !chipSelectN && !writeStrobeN;
    wire rdAct = !chipSelectN && !outEnableN && writeStrobeN;
    // floating lines toggle between 5a and a5, so a stale sample matches only those bytes
    always #10 floatV = ~floatV;
    // store when the overlap ends, whichever pin rises first
    always @(negedge wrAct) mem[addressLines] = dataLines;
    assign dataLines = !hostOeN ? hostData : (rdAct ? mem[addressLines] : floatV);
endmodule // asr_sram_model

// ---- test/tb_asr_ctrl.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmpCount++; if ((s) !== (e)) begin errTotal++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_asr_ctrl;
    localparam PWR = 20;
    logic        clock = 0, rst = 1, reqValid = 0, reqWrite = 0;
    logic [18:0] reqAddr = 0;
    logic [7:0]  reqData = 0;
    wire         reqReady, rspValid, chipSelectN, outEnableN, writeStrobeN, dataLinesOeN;
    wire [7:0]   rspData, dataLinesOut, dataLines;
    wire [18:0]  addressLines;
    int          errTotal = 0, cmpCount = 0, cyc = 0;
    logic [18:0] adr [3] = '{19'h00000, 19'h7ffff, 19'h2a5a5};
    logic [7:0]  dat [3] = '{8'ha5, 8'h5a, 8'hff};
    always #5 clock = ~clock;
    asr_ctrl #(.POWER_CYC(PWR)) u_dut (.clock(clock), .rst(rst), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .addressLines(addressLines),
        .chipSelectN(chipSelectN), .outEnableN(outEnableN), .writeStrobeN(writeStrobeN),
        .dataLinesIn(dataLines), .dataLinesOut(dataLinesOut), .dataLinesOeN(dataLinesOeN));
    asr_sram_model u_mem (.addressLines(addressLines), .chipSelectN(chipSelectN),
        .outEnableN(outEnableN), .writeStrobeN(writeStrobeN), .hostData(dataLinesOut),
        .hostOeN(dataLinesOeN), .dataLines(dataLines));
    task finalReport;
        $display("compares %0d errors %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard, well above the run length
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errTotal++;
            finalReport;
        end
    end
    task access(input logic w, input logic [18:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        reqValid <= 1; reqWrite <= w; reqAddr <= a; reqData <= d;
        @(posedge clock);
        while (reqReady !== 1'b1) @(posedge clock);
        reqValid <= 0;
        q = 8'hxx;
        for (int n = 0; n < 10 && !w; n++) begin
            @(posedge clock);
            if (rspValid === 1'b1) begin q = rspData; break; end
        end
    endtask
    task power_up_wait;
        int k;
        k = 0;
        while (reqReady !== 1'b1 && k < 100) begin
            @(posedge clock);
            k++;
            `CHK("csInWait", 1'b1, chipSelectN)
        end
        `CHK("waitLength", 1'b1, k >= PWR)
        `CHK("readyAfterWait", 1'b1, reqReady)
    endtask
    // extremes of the address range, then an overwrite
    task tData;
        logic [7:0] q;
        for (int i = 0; i < 3; i++) access(1, adr[i], dat[i], q);
        access(1, adr[1], 8'hc3, q);
        for (int i = 0; i < 3; i++) begin
            access(0, adr[i], 8'h00, q);
            `CHK("readBack", (i == 1) ? 8'hc3 : dat[i], q)
        end
        // write straight after a read: the memory must have let go first
        access(1, adr[2], 8'h3c, q);
        access(0, adr[2], 8'h00, q);
        `CHK("turnWrite", 8'h3c, q)
    endtask
    // reset lands in mid-strobe; the pins must go idle at once
    task tReset;
        @(posedge clock);
        reqValid <= 1; reqWrite <= 1; reqAddr <= 19'h1; reqData <= 8'h77;
        repeat (3) @(posedge clock);
        `CHK("strobeLow", 1'b0, writeStrobeN)
        rst <= 1; reqValid <= 0;
        @(posedge clock); #1;
        `CHK("pinsIdle", 4'hf, {chipSelectN, outEnableN, writeStrobeN, dataLinesOeN})
        @(posedge clock);
        rst <= 0;
        power_up_wait;
    endtask
    initial begin
        repeat (2) @(posedge clock);
        rst <= 0;
        power_up_wait;
        tData;
        tReset;
        tData;
        finalReport;
    end
endmodule // tb_asr_ctrl
